// *** famd_fetch_address_match_detector.v ***
// Fetch address match detector: registers, detect sequencer and interrupt logic
`timescale 1ns/1ns
`include "famd_regs.vh"

module famd_fetch_address_match_detector (
   input  wire        mclk,
   input  wire        srst,
   input  wire        clkEn,
   // Register port
   input  wire [3:0]  regAddr,
   input  wire [15:0] regWdata,
   input  wire        regWr,
   input  wire        regRd,
   output reg  [15:0] regRdata,
   // CPU fetch side
   input  wire        fetchStart,
   input  wire [7:0]  programBank,
   input  wire [15:0] programCounter,
   input  wire [15:0] processorStatus,
   output reg         nmiReq,
   input  wire        nmiAck,
   output reg         suppressExec,
   output reg  [7:0]  pushBank,
   output reg  [15:0] pushCounter,
   output reg  [15:0] pushStatus,
   // Interrupt
   output wire        irq
);

   // =================================================================
   // State
   // =================================================================
   localparam ST_IDLE = 2'b01;
   localparam ST_PEND = 2'b10;

   reg [1:0]  state_reg;
   reg [2:0]  ctl0_reg;
   reg        accEn_reg;
   reg        decision_reg;
   reg [23:0] cmp0_reg;
   reg [23:0] cmp1_reg;
   reg [1:0]  irqStat_reg;
   reg [1:0]  irqMask_reg;

   wire [1:0] condSel   = ctl0_reg[`FAMD_CTL0_SEL_LSB +: 2];
   wire       detectEn  = ctl0_reg[`FAMD_CTL0_EN_BIT];
   wire [23:0] fetchAddr = {programBank, programCounter};
   wire       condMet;
   wire       hitCmp1;

   // Decode of the compare register window
   function isCmpAddr;
      input [3:0] a;
      begin
         isCmpAddr = (a >= `FAMD_OFS_CMP0_LO) && (a <= `FAMD_OFS_CMP1_HI);
      end
   endfunction

   famd_compare u_cmp (
      .fetchAddr (fetchAddr),
      .cmp0      (cmp0_reg),
      .cmp1      (cmp1_reg),
      .condSel   (condSel),
      .condMet   (condMet),
      .hitCmp1   (hitCmp1)
   );

   // Hit only on instruction start, never on operand fetch
   wire detectHit = fetchStart && condMet && detectEn && state_reg[0];
   wire cmpBlocked = (regWr || regRd) && isCmpAddr(regAddr) && !accEn_reg;

   // =================================================================
   // Detect sequencer
   // =================================================================
   // Request holds until the CPU accepts, so the target is never executed first
   always @(posedge mclk) begin
      if (srst) begin
         state_reg    <= ST_IDLE;
         nmiReq       <= 1'b0;
         suppressExec <= 1'b0;
         pushBank     <= 8'h00;
         pushCounter  <= 16'h0000;
         pushStatus   <= 16'h0000;
         decision_reg <= 1'b0;
      end else if (clkEn) begin
         case (state_reg)
            ST_IDLE: begin
               if (detectHit) begin
                  state_reg    <= ST_PEND;
                  nmiReq       <= 1'b1;
                  suppressExec <= 1'b1;
                  pushBank     <= programBank;
                  pushCounter  <= programCounter;
                  pushStatus   <= processorStatus;
                  // Only meaningful under the either-register condition
                  if (condSel == `FAMD_COND_EITHER)
                     decision_reg <= hitCmp1;
               end
            end
            ST_PEND: begin
               if (nmiAck) begin
                  state_reg    <= ST_IDLE;
                  nmiReq       <= 1'b0;
                  suppressExec <= 1'b0;
               end
            end
            default: begin
               state_reg    <= ST_IDLE;
               nmiReq       <= 1'b0;
               suppressExec <= 1'b0;
            end
         endcase
      end
   end

   // =================================================================
   // Register writes
   // =================================================================
   always @(posedge mclk) begin
      if (srst) begin
         ctl0_reg    <= `FAMD_RST_CTL0;
         accEn_reg   <= 1'b0;
         cmp0_reg    <= `FAMD_RST_CMP;
         cmp1_reg    <= `FAMD_RST_CMP;
         irqMask_reg <= `FAMD_RST_IRQ;
      end else if (clkEn && regWr) begin
         case (regAddr)
            `FAMD_OFS_DBGCTL0: ctl0_reg <= regWdata[2:0];
            // Software opens this just before a compare access, closes after
            `FAMD_OFS_DBGCTL1: accEn_reg <= regWdata[`FAMD_CTL1_ACC_BIT];
            `FAMD_OFS_CMP0_LO: if (accEn_reg) cmp0_reg[15:0]  <= regWdata;
            `FAMD_OFS_CMP0_HI: if (accEn_reg) cmp0_reg[23:16] <= regWdata[7:0];
            `FAMD_OFS_CMP1_LO: if (accEn_reg) cmp1_reg[15:0]  <= regWdata;
            `FAMD_OFS_CMP1_HI: if (accEn_reg) cmp1_reg[23:16] <= regWdata[7:0];
            `FAMD_OFS_IRQ_MASK: irqMask_reg <= regWdata[1:0];
            default: ;
         endcase
      end
   end

   // =================================================================
   // Interrupt status: set wins over write-one-to-clear
   // =================================================================
   wire [1:0] irqSet = {cmpBlocked, detectHit};
   wire [1:0] irqClr = (regWr && regAddr == `FAMD_OFS_IRQ_STAT) ? regWdata[1:0] : 2'h0;

   always @(posedge mclk) begin
      if (srst)
         irqStat_reg <= `FAMD_RST_IRQ;
      else if (clkEn)
         irqStat_reg <= (irqStat_reg & ~irqClr) | irqSet;
   end

   assign irq = |(irqStat_reg & irqMask_reg);

   // =================================================================
   // Read data, one cycle after the strobe
   // =================================================================
   // Blocked compare reads return zero rather than stale contents
   always @(posedge mclk) begin
      if (srst) begin
         regRdata <= 16'h0000;
      end else if (clkEn) begin
         regRdata <= 16'h0000;
         if (regRd) begin
            case (regAddr)
               `FAMD_OFS_DBGCTL0: regRdata <= {13'h0000, ctl0_reg};
               `FAMD_OFS_DBGCTL1: regRdata <= {14'h0000, decision_reg, accEn_reg};
               `FAMD_OFS_CMP0_LO: if (accEn_reg) regRdata <= cmp0_reg[15:0];
               `FAMD_OFS_CMP0_HI: if (accEn_reg) regRdata <= {8'h00, cmp0_reg[23:16]};
               `FAMD_OFS_CMP1_LO: if (accEn_reg) regRdata <= cmp1_reg[15:0];
               `FAMD_OFS_CMP1_HI: if (accEn_reg) regRdata <= {8'h00, cmp1_reg[23:16]};
               `FAMD_OFS_IRQ_STAT: regRdata <= {14'h0000, irqStat_reg};
               `FAMD_OFS_IRQ_MASK: regRdata <= {14'h0000, irqMask_reg};
               `FAMD_OFS_SAVE_PS:  regRdata <= pushStatus;
               default: regRdata <= 16'h0000;
            endcase
         end
      end
   end

endmodule // famd_fetch_address_match_detector

// *** famd_regs.vh ***
// Register offsets, field positions, reset values and encodings of the fetch address match detector
// =====================================================================
// =====================================================================
`ifndef FAMD_REGS_VH
`define FAMD_REGS_VH

// Register addresses on the plain register port
`define FAMD_ADDR_W        4
`define FAMD_OFS_DBGCTL0   4'h0
`define FAMD_OFS_DBGCTL1   4'h1
`define FAMD_OFS_CMP0_LO   4'h2
`define FAMD_OFS_CMP0_HI   4'h3
`define FAMD_OFS_CMP1_LO   4'h4
`define FAMD_OFS_CMP1_HI   4'h5
`define FAMD_OFS_IRQ_STAT  4'h6
`define FAMD_OFS_IRQ_MASK  4'h7
`define FAMD_OFS_SAVE_PS   4'h8

// Debug control 0 fields
`define FAMD_CTL0_SEL_LSB  0
`define FAMD_CTL0_EN_BIT   2
// Debug control 1 fields
`define FAMD_CTL1_ACC_BIT  0
`define FAMD_CTL1_DEC_BIT  1

// Detect conditions
`define FAMD_COND_MATCH0   2'h0
`define FAMD_COND_MATCH1   2'h1
`define FAMD_COND_EITHER   2'h2
`define FAMD_COND_OUTAREA  2'h3

// Interrupt status bits
`define FAMD_IRQ_DETECT    0
`define FAMD_IRQ_BLOCKED   1

// Reset values
`define FAMD_RST_CTL0      3'h0
`define FAMD_RST_CMP       24'h000000
`define FAMD_RST_IRQ       2'h0

`endif

// *** famd_compare.v ***
// Address comparator that evaluates the selected detect condition
`timescale 1ns/1ns
`include "famd_regs.vh"

module famd_compare (
   input  wire [23:0] fetchAddr,
   input  wire [23:0] cmp0,
   input  wire [23:0] cmp1,
   input  wire [1:0]  condSel,
   output reg         condMet,
   output reg         hitCmp1
);

   // =================================================================
   // Condition evaluation
   // =================================================================
   // Pure combinational; the caller decides when the result counts
   always @* begin
      condMet = 1'b0;
      hitCmp1 = 1'b0;
      case (condSel)
         `FAMD_COND_MATCH0: condMet = (fetchAddr == cmp0);
         `FAMD_COND_MATCH1: condMet = (fetchAddr == cmp1);
         `FAMD_COND_EITHER: begin
            condMet = (fetchAddr == cmp0) || (fetchAddr == cmp1);
            hitCmp1 = (fetchAddr != cmp0) && (fetchAddr == cmp1);
         end
         `FAMD_COND_OUTAREA: condMet = (fetchAddr < cmp0) || (fetchAddr > cmp1);
         default: condMet = 1'b0;
      endcase
   end

endmodule // famd_compare

// *** famd_checker.sv ***
// Port-level assertions for the fetch address match detector
`timescale 1ns/1ns
module famd_checker (
   input wire logic        mclk, srst, clkEn, regWr, regRd, fetchStart,
   input wire logic        nmiReq, nmiAck, suppressExec,
   input wire logic [3:0]  regAddr,
   input wire logic [15:0] regWdata, regRdata, programCounter, processorStatus,
   input wire logic [15:0] pushCounter, pushStatus,
   input wire logic [7:0]  programBank, pushBank
);
   logic accSh_reg = 1'h0;
   logic enSh_reg  = 1'h0;
   // ==========
   // Shadows of access enable and detect enable, seen only through writes
   always @(posedge mclk) begin
      if (srst) begin
         accSh_reg <= 1'h0;
         enSh_reg  <= 1'h0;
      end else if (clkEn && regWr && regAddr == 4'h1) begin
         accSh_reg <= regWdata[0];
      end else if (clkEn && regWr && regAddr == 4'h0) begin
         enSh_reg <= regWdata[2];
      end
   end
   default clocking @(posedge mclk); endclocking
   default disable iff (srst);
   a_ack_drop: assert property (nmiReq && nmiAck && clkEn |=> !nmiReq)
      else $error("request kept after ack");
   a_req_hold: assert property (nmiReq && !nmiAck && clkEn |=> nmiReq)
      else $error("request lost before ack");
   a_supp_pair: assert property (suppressExec == nmiReq)
      else $error("suppress differs from request");
   a_push_capture: assert property ($rose(nmiReq) |-> pushBank == $past(programBank)
      && pushCounter == $past(programCounter) && pushStatus == $past(processorStatus))
      else $error("pushed state wrong");
   a_rise_cause: assert property ($rose(nmiReq) |-> $past(fetchStart) && $past(enSh_reg))
      else $error("request without enabled fetch");
   a_quiet_off: assert property (!enSh_reg && !nmiReq && fetchStart |=> !nmiReq)
      else $error("request while disabled");
   a_push_hold: assert property (nmiReq && !$rose(nmiReq) |-> $stable(pushCounter))
      else $error("pending capture overwritten");
   a_cmp_block: assert property (regRd && clkEn && !accSh_reg && regAddr >= 4'h2
      && regAddr <= 4'h5 |=> regRdata == 16'h0000) else $error("blocked read leaked");
endmodule // famd_checker
bind famd_fetch_address_match_detector famd_checker chk_u (.*);

// *** famd_cpu_model.sv ***
// CPU fetch and interrupt acceptance model facing the detector
`timescale 1ns/1ns
module famd_cpu_model (
   input  wire logic       mclk,
   input  wire logic       nmiReq,
   input  wire logic [3:0] ackWait,
   output logic            fetchStart = 1'h0,
   output logic [7:0]      programBank = 8'h00,
   output logic [15:0]     programCounter = 16'h0000,
   output logic [15:0]     processorStatus = 16'h0000,
   output logic            nmiAck = 1'h0
);
   logic [3:0] waitCnt = 4'h0;
   // One instruction start; address scrambled outside the start cycle
   task automatic fetch(input logic [23:0] addr);
      @(posedge mclk);
      fetchStart <= 1'h1;
      {programBank, programCounter} <= addr;
      processorStatus <= addr[15:0] ^ 16'h5A5A;
      @(posedge mclk);
      fetchStart <= 1'h0;
      {programBank, programCounter} <= ~addr;
      processorStatus <= ~processorStatus;
   endtask
   // Slow acceptance keeps the request pending so late hits can be tried
   always @(posedge mclk) begin
      if (nmiReq && !nmiAck && waitCnt >= ackWait) begin
         nmiAck  <= 1'h1;
         waitCnt <= 4'h0;
      end else begin
         nmiAck  <= 1'h0;
         waitCnt <= (nmiReq && !nmiAck) ? waitCnt + 4'h1 : 4'h0;
      end
   end
endmodule // famd_cpu_model

// *** famd_fetch_address_match_detector_tb_top.sv ***
// Self-checking bench for the fetch address match detector
`timescale 1ns/1ns
`include "famd_regs.vh"
module famd_fetch_address_match_detector_tb_top;
   localparam logic [23:0] CMP0 = 24'h012340, CMP1 = 24'h015670;
   logic        mclk = 1'h0, srst = 1'h1, clkEn = 1'h1, regWr = 1'h0, regRd = 1'h0;
   logic        irq, fetchStart, nmiReq, nmiAck, suppressExec;
   logic [3:0]  regAddr = 4'h0, ackWait = 4'h0;
   logic [15:0] regWdata = 16'h0000, regRdata, pushCounter, pushStatus;
   logic [15:0] programCounter, processorStatus;
   logic [7:0]  pushBank, programBank;
   logic [23:0] addrs [6] = '{CMP0, CMP1, CMP0 - 24'h1, CMP1 + 24'h1, 24'h014000, 24'h002340};
   int          badCount = 0, totalChecks = 0, cycles = 0;
   famd_fetch_address_match_detector dut_u (.*);
   famd_cpu_model cpu_u (.*);
   // ==========
   // Clock and hang guard
   always #25 mclk = ~mclk;
   always @(posedge mclk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         badCount++;
         wrap_up();
      end
   end
   task automatic check(input logic ok, input string msg);
      totalChecks++;
      if (ok !== 1'h1) begin
         badCount++;
         $display("mismatch at %0t: %s", $time, msg);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge mclk);
      regWr <= 1'h1;
      regAddr <= a;
      regWdata <= d;
      @(posedge mclk);
      regWr <= 1'h0;
   endtask
   task automatic rd(input logic [3:0] a, output logic [15:0] d);
      @(posedge mclk);
      regRd <= 1'h1;
      regAddr <= a;
      @(posedge mclk);
      regRd <= 1'h0;
      #1 d = regRdata;
   endtask
   // Compare access bracketed by the access enable, as software must
   task automatic cmpWr(input logic [3:0] a, input logic [15:0] d);
      wr(`FAMD_OFS_DBGCTL1, 16'h0001);
      wr(a, d);
      wr(`FAMD_OFS_DBGCTL1, 16'h0000);
   endtask
   // Reset value, blocked write with its status bit, unmapped read
   task automatic testBlocked();
      logic [15:0] v;
      rd(`FAMD_OFS_DBGCTL0, v);
      check(v === 16'h0000, "control reset value");
      wr(`FAMD_OFS_IRQ_MASK, 16'h0003);
      wr(`FAMD_OFS_CMP0_LO, 16'h1234);
      #1 check(irq === 1'h1, "blocked access irq");
      wr(`FAMD_OFS_IRQ_STAT, 16'h0002);
      #1 check(irq === 1'h0, "irq clear");
      wr(`FAMD_OFS_DBGCTL1, 16'h0001);
      rd(`FAMD_OFS_CMP0_LO, v);
      wr(`FAMD_OFS_DBGCTL1, 16'h0000);
      check(v === 16'h0000, "blocked write landed");
      rd(4'hF, v);
      check(v === 16'h0000, "unmapped read");
   endtask
   // Clock enable low must freeze the registers, so a write in that time is lost
   task automatic testFreeze();
      logic [15:0] v;
      @(posedge mclk);
      clkEn <= 1'h0;
      wr(`FAMD_OFS_DBGCTL0, 16'h0007);
      @(posedge mclk);
      clkEn <= 1'h1;
      rd(`FAMD_OFS_DBGCTL0, v);
      check(v === 16'h0000, "write taken while frozen");
   endtask
   task automatic testSetup();
      logic [15:0] v;
      cmpWr(`FAMD_OFS_CMP0_LO, CMP0[15:0]);
      cmpWr(`FAMD_OFS_CMP0_HI, {8'h00, CMP0[23:16]});
      cmpWr(`FAMD_OFS_CMP1_LO, CMP1[15:0]);
      cmpWr(`FAMD_OFS_CMP1_HI, {8'h00, CMP1[23:16]});
      rd(`FAMD_OFS_CMP1_LO, v);
      check(v === 16'h0000, "blocked read");
      wr(`FAMD_OFS_DBGCTL1, 16'h0001);
      rd(`FAMD_OFS_CMP1_LO, v);
      wr(`FAMD_OFS_DBGCTL1, 16'h0000);
      check(v === CMP1[15:0], "compare read back");
      wr(`FAMD_OFS_IRQ_STAT, 16'h0003);
   endtask
   // One fetch under a condition; a hit is checked, the next address fetched while pending, acked
   task automatic runFetch(input logic [1:0] c, input logic en, input logic [23:0] a);
      logic hit;
      logic [15:0] v;
      int k;
      hit = en && (c == 2'h0 ? a == CMP0 : c == 2'h1 ? a == CMP1 :
         c == 2'h2 ? (a == CMP0 || a == CMP1) : (a < CMP0 || a > CMP1));
      wr(`FAMD_OFS_DBGCTL0, {13'h0000, en, c});
      cpu_u.fetch(a);
      #1 check(nmiReq === hit, "request level");
      if (hit) begin
         check(suppressExec === 1'h1 && irq === 1'h1, "suppress or irq");
         check({pushBank, pushCounter} === a && pushStatus === (a[15:0] ^ 16'h5A5A), "push");
         cpu_u.fetch(a + 24'h1);
         #1 check({pushBank, pushCounter} === a, "pending capture");
         for (k = 0; k < 20 && nmiReq === 1'h1; k++) @(posedge mclk);
         #1 check(nmiReq === 1'h0, "request not released");
         rd(`FAMD_OFS_DBGCTL1, v);
         if (c == 2'h2) check(v[1] === (a == CMP1), "decision bit");
         wr(`FAMD_OFS_IRQ_STAT, 16'h0001);
         #1 check(irq === 1'h0, "detect status clear");
      end
   endtask
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", totalChecks, badCount);
      if (badCount == 0 && totalChecks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   initial begin
      repeat (16) @(posedge mclk);
      srst <= 1'h0;
      testBlocked();
      testFreeze();
      testSetup();
      for (int c = 0; c < 4; c++) begin
         @(posedge mclk);
         ackWait <= (c[0]) ? 4'h3 : 4'h0;
         foreach (addrs[i]) runFetch(c[1:0], 1'h1, addrs[i]);
      end
      runFetch(2'h0, 1'h0, CMP0);
      wrap_up();
   end
endmodule // famd_fetch_address_match_detector_tb_top
